// ### shared/rmt_consts.vh
`ifndef RMT_CONSTS_VH
`define RMT_CONSTS_VH

// register offsets (8-bit address space)
`define RMT_ADDR_TONE1_CTRL      8'h20
`define RMT_ADDR_RING_CTRL       8'h22
`define RMT_ADDR_METER_CTRL      8'h23
`define RMT_ADDR_TONE1_ON_LO     8'h24
`define RMT_ADDR_TONE1_ON_HI     8'h25
`define RMT_ADDR_TONE1_OFF_LO    8'h26
`define RMT_ADDR_TONE1_OFF_HI    8'h27
`define RMT_ADDR_METER_ON_LO     8'h2C
`define RMT_ADDR_METER_ON_HI     8'h2D
`define RMT_ADDR_METER_OFF_LO    8'h2E
`define RMT_ADDR_METER_OFF_HI    8'h2F
`define RMT_ADDR_RING_ON_LO      8'h30
`define RMT_ADDR_RING_ON_HI      8'h31
`define RMT_ADDR_RING_OFF_LO     8'h32
`define RMT_ADDR_RING_OFF_HI     8'h33
`define RMT_ADDR_RING_START      8'h40

// control register field positions
`define RMT_BIT_STATUS           7
`define RMT_BIT_ON_LINE          5
`define RMT_BIT_ON_TIMER_EN      4
`define RMT_BIT_OFF_TIMER_EN     3
`define RMT_BIT_OSC_EN           2
`define RMT_BIT_DC_OFFSET        1
`define RMT_BIT_SHAPE            0
`define RMT_BIT_RING_START       0

// reset values
`define RMT_RESET_BYTE           8'h00
`define RMT_RESET_WORD           16'h0000

// cadence step: 125 us at a 25 ns clock
`define RMT_STEP_NS              125000
`define RMT_CLK_NS               25
`define RMT_STEP_CYCLES          (`RMT_STEP_NS / `RMT_CLK_NS)

// cadence engine states
`define RMT_ST_IDLE              2'd0
`define RMT_ST_ON                2'd1
`define RMT_ST_OFF               2'd2

// channel indices
`define RMT_CH_TONE1             0
`define RMT_CH_METER             1
`define RMT_CH_RING              2

`endif

// ### src/rmt_regs.v
// Function
// - ring ctrl bit7 shows ringing output active
// - ring drive changes only at dc level
// - ring ctrl bit5 shows ringing on line
// - ring ctrl bit4 enables ringing active timer
// - ring ctrl bit3 enables ringing inactive timer
// - ring ctrl bit2 shows ringing oscillator enabled
// - ring ctrl bit1 adds dc offset
// - ring ctrl bit0 selects sine or trapezoid
// - meter ctrl bit7 shows metering output active
// - meter ctrl bit4 enables metering active timer
// - meter ctrl bit3 enables metering inactive timer
// - meter ctrl bit2 enables metering oscillator
// - tone1 active duration 16 bits, 125us steps
// - tone1 inactive duration 16 bits, 125us steps
// - meter ctrl and tone1 timers reset zero
// - tone1 active timer used only when enabled
// - ringing active duration own 16-bit pair
`include "rmt_consts.vh"

module rmt_regs #(
    parameter STEP_CYCLES = `RMT_STEP_CYCLES
) (
    input  wire       mclk,
    input  wire       sys_rst,
    input  wire [7:0] addr,
    input  wire [7:0] wr_data,
    input  wire       wr_en,
    input  wire       rd_en,
    input  wire       ring_at_dc_level,
    output reg  [7:0] rd_data,
    output reg        tone1_active,
    output reg        meter_active,
    output reg        ring_output_active,
    output reg        ring_drive_en,
    output reg        ring_dc_offset_en,
    output reg        ring_shape_sel
);

    localparam ST_IDLE = `RMT_ST_IDLE;
    localparam ST_ON   = `RMT_ST_ON;
    localparam ST_OFF  = `RMT_ST_OFF;

    // phase ends on the step that completes the programmed count
    function step_done;
        input [15:0] cnt;
        input [15:0] dur;
        begin
            step_done = ({1'b0, cnt} + 17'h0_0001) >= {1'b0, dur};
        end
    endfunction

    // phase counter advance; kept apart so both phases wrap the same way
    // a zero duration still costs one step, never a zero-length phase
    function [15:0] step_inc;
        input [15:0] cnt;
        begin
            step_inc = cnt + 16'h0001;
        end
    endfunction

    // software-visible state
    reg        tone1_on_timer_en;
    reg        tone1_off_timer_en;
    reg        tone1_osc_en;
    reg        ring_on_timer_en;
    reg        ring_off_timer_en;
    reg        ring_osc_en;
    reg        meter_on_timer_en;
    reg        meter_off_timer_en;
    reg        meter_osc_en;
    reg [15:0] tone1_on_duration;
    reg [15:0] tone1_off_duration;
    reg [15:0] meter_on_duration;
    reg [15:0] meter_off_duration;
    reg [15:0] ring_on_duration;
    reg [15:0] ring_off_duration;

    // cadence engines
    reg [1:0]  st      [0:2];
    reg [15:0] cnt     [0:2];
    reg [1:0]  next_st [0:2];
    reg [15:0] next_cnt[0:2];
    reg [2:0]  ch_en;
    reg [2:0]  ch_on_en;
    reg [2:0]  ch_off_en;
    reg [15:0] ch_on_dur [0:2];
    reg [15:0] ch_off_dur[0:2];

    reg [15:0] pre_cnt;
    reg        step_tick;
    reg [7:0]  next_rd;
    integer    i;

    // 125 us step prescaler, free running; first step after enable may be short
    // one prescaler for all channels: cheaper than three, at the cost of
    // up to one step of jitter on the first phase after an enable
    // step_tick is registered, so every engine sees it for exactly one clock
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pre_cnt   <= 16'h0000;
            step_tick <= 1'b0;
        end else if (pre_cnt == STEP_CYCLES[15:0] - 16'h0001) begin
            pre_cnt   <= 16'h0000;
            step_tick <= 1'b1;
        end else begin
            pre_cnt   <= pre_cnt + 16'h0001;
            step_tick <= 1'b0;
        end
    end

    // register writes; only documented bits are stored
    // duration bytes land independently, no high/low latching:
    // software should write both halves while the channel is idle
    // status bits are never stored here, they are rebuilt on read
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tone1_on_timer_en  <= 1'b0;
            tone1_off_timer_en <= 1'b0;
            tone1_osc_en       <= 1'b0;
            ring_on_timer_en   <= 1'b0;
            ring_off_timer_en  <= 1'b0;
            ring_osc_en        <= 1'b0;
            ring_dc_offset_en  <= 1'b0;
            ring_shape_sel     <= 1'b0;
            meter_on_timer_en  <= 1'b0;
            meter_off_timer_en <= 1'b0;
            meter_osc_en       <= 1'b0;
            tone1_on_duration  <= `RMT_RESET_WORD;
            tone1_off_duration <= `RMT_RESET_WORD;
            meter_on_duration  <= `RMT_RESET_WORD;
            meter_off_duration <= `RMT_RESET_WORD;
            ring_on_duration   <= `RMT_RESET_WORD;
            ring_off_duration  <= `RMT_RESET_WORD;
        end else if (wr_en) begin
            case (addr)
                `RMT_ADDR_TONE1_CTRL: begin
                    tone1_on_timer_en  <= wr_data[`RMT_BIT_ON_TIMER_EN];
                    tone1_off_timer_en <= wr_data[`RMT_BIT_OFF_TIMER_EN];
                    tone1_osc_en       <= wr_data[`RMT_BIT_OSC_EN];
                end
                `RMT_ADDR_RING_CTRL: begin
                    // status bits and the reserved bit drop writes
                    ring_on_timer_en  <= wr_data[`RMT_BIT_ON_TIMER_EN];
                    ring_off_timer_en <= wr_data[`RMT_BIT_OFF_TIMER_EN];
                    ring_dc_offset_en <= wr_data[`RMT_BIT_DC_OFFSET];
                    ring_shape_sel    <= wr_data[`RMT_BIT_SHAPE];
                end
                `RMT_ADDR_METER_CTRL: begin
                    meter_on_timer_en  <= wr_data[`RMT_BIT_ON_TIMER_EN];
                    meter_off_timer_en <= wr_data[`RMT_BIT_OFF_TIMER_EN];
                    meter_osc_en       <= wr_data[`RMT_BIT_OSC_EN];
                end
                `RMT_ADDR_TONE1_ON_LO: begin
                    tone1_on_duration[7:0] <= wr_data;
                end
                `RMT_ADDR_TONE1_ON_HI: begin
                    tone1_on_duration[15:8] <= wr_data;
                end
                `RMT_ADDR_TONE1_OFF_LO: begin
                    tone1_off_duration[7:0] <= wr_data;
                end
                `RMT_ADDR_TONE1_OFF_HI: begin
                    tone1_off_duration[15:8] <= wr_data;
                end
                `RMT_ADDR_METER_ON_LO: begin
                    meter_on_duration[7:0] <= wr_data;
                end
                `RMT_ADDR_METER_ON_HI: begin
                    meter_on_duration[15:8] <= wr_data;
                end
                `RMT_ADDR_METER_OFF_LO: begin
                    meter_off_duration[7:0] <= wr_data;
                end
                `RMT_ADDR_METER_OFF_HI: begin
                    meter_off_duration[15:8] <= wr_data;
                end
                `RMT_ADDR_RING_ON_LO: begin
                    ring_on_duration[7:0] <= wr_data;
                end
                `RMT_ADDR_RING_ON_HI: begin
                    ring_on_duration[15:8] <= wr_data;
                end
                `RMT_ADDR_RING_OFF_LO: begin
                    ring_off_duration[7:0] <= wr_data;
                end
                `RMT_ADDR_RING_OFF_HI: begin
                    ring_off_duration[15:8] <= wr_data;
                end
                // ring enable lives apart so the ctrl byte can show it read-only
                `RMT_ADDR_RING_START: begin
                    ring_osc_en <= wr_data[`RMT_BIT_RING_START];
                end
                default: begin
                end
            endcase
        end
    end

    // per-channel views so one engine loop serves all three
    always @* begin
        ch_en[`RMT_CH_TONE1]      = tone1_osc_en;
        ch_en[`RMT_CH_METER]      = meter_osc_en;
        ch_en[`RMT_CH_RING]       = ring_osc_en;
        ch_on_en[`RMT_CH_TONE1]   = tone1_on_timer_en;
        ch_on_en[`RMT_CH_METER]   = meter_on_timer_en;
        ch_on_en[`RMT_CH_RING]    = ring_on_timer_en;
        ch_off_en[`RMT_CH_TONE1]  = tone1_off_timer_en;
        ch_off_en[`RMT_CH_METER]  = meter_off_timer_en;
        ch_off_en[`RMT_CH_RING]   = ring_off_timer_en;
        ch_on_dur[`RMT_CH_TONE1]  = tone1_on_duration;
        ch_on_dur[`RMT_CH_METER]  = meter_on_duration;
        ch_on_dur[`RMT_CH_RING]   = ring_on_duration;
        ch_off_dur[`RMT_CH_TONE1] = tone1_off_duration;
        ch_off_dur[`RMT_CH_METER] = meter_off_duration;
        ch_off_dur[`RMT_CH_RING]  = ring_off_duration;
    end

    // cadence: active for on-duration, silent for off-duration, repeat
    // clearing the enable drops to idle at once, mid-phase; the tone
    // generator behind this must accept an abrupt stop
    always @* begin
        for (i = 0; i < 3; i = i + 1) begin
            next_st[i]  = st[i];
            next_cnt[i] = cnt[i];
            case (st[i])
                ST_IDLE: begin
                    if (ch_en[i]) begin
                        next_st[i]  = ST_ON;
                        next_cnt[i] = 16'h0000;
                    end
                end
                ST_ON: begin
                    // without the active timer the tone stays on
                    if (!ch_en[i]) begin
                        next_st[i] = ST_IDLE;
                    end else if (ch_on_en[i] && step_tick) begin
                        if (step_done(cnt[i], ch_on_dur[i])) begin
                            next_st[i]  = ST_OFF;
                            next_cnt[i] = 16'h0000;
                        end else begin
                            next_cnt[i] = step_inc(cnt[i]);
                        end
                    end
                end
                ST_OFF: begin
                    // without the inactive timer it stays silent until re-enabled
                    if (!ch_en[i]) begin
                        next_st[i] = ST_IDLE;
                    end else if (ch_off_en[i] && step_tick) begin
                        if (step_done(cnt[i], ch_off_dur[i])) begin
                            next_st[i]  = ST_ON;
                            next_cnt[i] = 16'h0000;
                        end else begin
                            next_cnt[i] = step_inc(cnt[i]);
                        end
                    end
                end
                default: begin
                    next_st[i]  = ST_IDLE;
                    next_cnt[i] = 16'h0000;
                end
            endcase
        end
    end

    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            for (i = 0; i < 3; i = i + 1) begin
                st[i]  <= ST_IDLE;
                cnt[i] <= 16'h0000;
            end
            tone1_active       <= 1'b0;
            meter_active       <= 1'b0;
            ring_output_active <= 1'b0;
        end else begin
            for (i = 0; i < 3; i = i + 1) begin
                st[i]  <= next_st[i];
                cnt[i] <= next_cnt[i];
            end
            tone1_active       <= next_st[`RMT_CH_TONE1] == ST_ON;
            meter_active       <= next_st[`RMT_CH_METER] == ST_ON;
            ring_output_active <= next_st[`RMT_CH_RING] == ST_ON;
        end
    end

    // line drive follows the ringing output only at the dc crossing, avoiding a step
    // if the crossing input never pulses, the line keeps its last state
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ring_drive_en <= 1'b0;
        end else if (ring_at_dc_level) begin
            ring_drive_en <= ring_output_active;
        end
    end

    // read mux; unmapped addresses read zero
    // reserved bits stay at the zero default, writes never reach them
    always @* begin
        next_rd = 8'h00;
        case (addr)
            `RMT_ADDR_TONE1_CTRL: begin
                next_rd[`RMT_BIT_STATUS]       = tone1_active;
                next_rd[`RMT_BIT_ON_TIMER_EN]  = tone1_on_timer_en;
                next_rd[`RMT_BIT_OFF_TIMER_EN] = tone1_off_timer_en;
                next_rd[`RMT_BIT_OSC_EN]       = tone1_osc_en;
            end
            `RMT_ADDR_RING_CTRL: begin
                next_rd[`RMT_BIT_STATUS]       = ring_output_active;
                next_rd[`RMT_BIT_ON_LINE]      = ring_drive_en;
                next_rd[`RMT_BIT_ON_TIMER_EN]  = ring_on_timer_en;
                next_rd[`RMT_BIT_OFF_TIMER_EN] = ring_off_timer_en;
                next_rd[`RMT_BIT_OSC_EN]       = ring_osc_en;
                next_rd[`RMT_BIT_DC_OFFSET]    = ring_dc_offset_en;
                next_rd[`RMT_BIT_SHAPE]        = ring_shape_sel;
            end
            `RMT_ADDR_METER_CTRL: begin
                next_rd[`RMT_BIT_STATUS]       = meter_active;
                next_rd[`RMT_BIT_ON_TIMER_EN]  = meter_on_timer_en;
                next_rd[`RMT_BIT_OFF_TIMER_EN] = meter_off_timer_en;
                next_rd[`RMT_BIT_OSC_EN]       = meter_osc_en;
            end
            `RMT_ADDR_TONE1_ON_LO: begin
                next_rd = tone1_on_duration[7:0];
            end
            `RMT_ADDR_TONE1_ON_HI: begin
                next_rd = tone1_on_duration[15:8];
            end
            `RMT_ADDR_TONE1_OFF_LO: begin
                next_rd = tone1_off_duration[7:0];
            end
            `RMT_ADDR_TONE1_OFF_HI: begin
                next_rd = tone1_off_duration[15:8];
            end
            `RMT_ADDR_METER_ON_LO: begin
                next_rd = meter_on_duration[7:0];
            end
            `RMT_ADDR_METER_ON_HI: begin
                next_rd = meter_on_duration[15:8];
            end
            `RMT_ADDR_METER_OFF_LO: begin
                next_rd = meter_off_duration[7:0];
            end
            `RMT_ADDR_METER_OFF_HI: begin
                next_rd = meter_off_duration[15:8];
            end
            `RMT_ADDR_RING_ON_LO: begin
                next_rd = ring_on_duration[7:0];
            end
            `RMT_ADDR_RING_ON_HI: begin
                next_rd = ring_on_duration[15:8];
            end
            `RMT_ADDR_RING_OFF_LO: begin
                next_rd = ring_off_duration[7:0];
            end
            `RMT_ADDR_RING_OFF_HI: begin
                next_rd = ring_off_duration[15:8];
            end
            `RMT_ADDR_RING_START: begin
                next_rd[`RMT_BIT_RING_START] = ring_osc_en;
            end
            default:                next_rd = 8'h00;
        endcase
    end

    // read data valid only in the cycle after the strobe
    // forced back to zero so a stale byte is never mistaken for a fresh one
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data <= 8'h00;
        end else if (rd_en) begin
            rd_data <= next_rd;
        end else begin
            rd_data <= 8'h00;
        end
    end

endmodule

// ### verif/rmt_regs_assertions.sv
`include "rmt_consts.vh"
module rmt_regs_checker (
    input wire       mclk,
    input wire       sys_rst,
    input wire [7:0] addr,
    input wire [7:0] wr_data,
    input wire       wr_en,
    input wire       rd_en,
    input wire       ring_at_dc_level,
    input wire [7:0] rd_data,
    input wire       tone1_active,
    input wire       meter_active,
    input wire       ring_output_active,
    input wire       ring_drive_en,
    input wire       ring_dc_offset_en,
    input wire       ring_shape_sel
);
    timeunit 1ns;
    timeprecision 1ps;
    reg ring_en_q;
    // shadow of the ring oscillator enable, so bit 2 can be judged
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst)
            ring_en_q <= 1'b0;
        else if (wr_en && addr == `RMT_ADDR_RING_START)
            ring_en_q <= wr_data[0];
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence ring_rd_s;
        rd_en && addr == `RMT_ADDR_RING_CTRL;
    endsequence
    sequence meter_rd_s;
        rd_en && addr == `RMT_ADDR_METER_CTRL;
    endsequence
    sequence ring_wr_s;
        wr_en && addr == `RMT_ADDR_RING_CTRL;
    endsequence
    read_idle_a: assert property (!rd_en |=> rd_data == 8'h00)
        else $error("read data not idle");
    ring_status_a: assert property (ring_rd_s |=> rd_data[7] == $past(ring_output_active)
        && rd_data[5] == $past(ring_drive_en) && !rd_data[6])
        else $error("ring status bits wrong");
    ring_enable_a: assert property (ring_rd_s |=> rd_data[2] == $past(ring_en_q))
        else $error("ring enable bit wrong");
    meter_status_a: assert property (meter_rd_s |=> rd_data[7] == $past(meter_active)
        && rd_data[6:5] == 2'b00 && rd_data[1:0] == 2'b00)
        else $error("meter status bits wrong");
    ring_bits_a: assert property (ring_wr_s
        |=> {6'h00, ring_dc_offset_en, ring_shape_sel} == ($past(wr_data) & 8'h03))
        else $error("offset or shape not written");
    ring_bits_hold_a: assert property (!(wr_en && addr == `RMT_ADDR_RING_CTRL)
        |=> $stable(ring_dc_offset_en) && $stable(ring_shape_sel))
        else $error("offset or shape moved without write");
    dc_only_a: assert property ($changed(ring_drive_en) |-> $past(ring_at_dc_level))
        else $error("line drive switched off dc level");
    drive_follow_a: assert property (ring_at_dc_level
        |=> ring_drive_en == $past(ring_output_active))
        else $error("line drive did not follow ringing");
    meter_stop_a: assert property (wr_en && addr == `RMT_ADDR_METER_CTRL && !wr_data[2]
        |-> ##2 !meter_active)
        else $error("meter active after disable");
    tone_stop_a: assert property (wr_en && addr == `RMT_ADDR_TONE1_CTRL && !wr_data[2]
        |-> ##2 !tone1_active)
        else $error("tone1 active after disable");
    ring_stop_a: assert property (wr_en && addr == `RMT_ADDR_RING_START && !wr_data[0]
        |-> ##2 !ring_output_active)
        else $error("ringing active after disable");
endmodule

bind rmt_regs rmt_regs_checker rmt_regs_checker_inst (.mclk, .sys_rst, .addr, .wr_data,
    .wr_en, .rd_en, .ring_at_dc_level, .rd_data, .tone1_active, .meter_active,
    .ring_output_active, .ring_drive_en, .ring_dc_offset_en, .ring_shape_sel);

// ### verif/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STEP = 8;
    logic       mclk, sys_rst, wr_en, rd_en, ring_at_dc_level;
    logic [7:0] addr, wr_data, v;
    wire  [7:0] rd_data;
    wire        tone1_active, meter_active, ring_output_active;
    wire        ring_drive_en, ring_dc_offset_en, ring_shape_sel;
    wire  [2:0] act = {ring_output_active, meter_active, tone1_active};
    int         bad_count = 0, n_compared = 0, cycles = 0, n, i;
    logic [23:0] rows [8];
`define CHK(g, e) begin if ((g) !== (e)) begin \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); bad_count++; end n_compared++; end

    rmt_regs #(.STEP_CYCLES(STEP)) rmt_regs_inst (.mclk, .sys_rst, .addr, .wr_data, .wr_en,
        .rd_en, .ring_at_dc_level, .rd_data, .tone1_active, .meter_active,
        .ring_output_active, .ring_drive_en, .ring_dc_offset_en, .ring_shape_sel);

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task give_verdict;
        if (bad_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // generous ceiling: the longest case is a few hundred cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 6000) begin
            bad_count++;
            give_verdict;
        end
    end
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1 v = rd_data;
    endtask
    // cycles until the chosen cadence output reaches lv
    task span(input int s, input logic lv, output int k);
        k = 0;
        #1;
        while (act[s] !== lv && k < 300) begin
            @(posedge mclk);
            #1;
            k++;
        end
    endtask
    task dc_pulse;
        @(posedge mclk);
        ring_at_dc_level <= 1'b1;
        @(posedge mclk);
        ring_at_dc_level <= 1'b0;
    endtask

    initial begin
        {sys_rst, wr_en, rd_en, ring_at_dc_level} = 4'h8;
        addr = 8'h00;
        wr_data = 8'h00;
        // address, write value, read-back value
        rows = '{24'h22_ff1b, 24'h23_f818, 24'h24_a5a5, 24'h25_5a5a,
                 24'h26_c3c3, 24'h27_3c3c, 24'h50_ff00, 24'h20_1818};
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        for (i = 0; i < 8; i++) begin
            rd(rows[i][23:16]);
            `CHK(v, 8'h00)
        end
        for (i = 0; i < 8; i++) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16]);
            `CHK(v, rows[i][7:0])
        end
        `CHK({ring_dc_offset_en, ring_shape_sel}, 2'b11)
        wr(8'h22, 8'h01);
        #1 `CHK({ring_dc_offset_en, ring_shape_sel}, 2'b01)
        wr(8'h24, 8'h02);
        wr(8'h25, 8'h00);
        wr(8'h26, 8'h01);
        wr(8'h27, 8'h00);
        wr(8'h20, 8'h1c);
        // first phase may start mid-step, so time the second round
        span(0, 1'b1, n);
        span(0, 1'b0, n);
        span(0, 1'b1, n);
        `CHK(n, 1 * STEP)
        span(0, 1'b0, n);
        `CHK(n, 2 * STEP)
        wr(8'h20, 8'h00);
        wr(8'h20, 8'h04);
        span(0, 1'b1, n);
        repeat (40) @(posedge mclk);
        #1 `CHK(tone1_active, 1'b1)
        wr(8'h20, 8'h00);
        wr(8'h2c, 8'h01);
        wr(8'h23, 8'h04);
        span(1, 1'b1, n);
        rd(8'h23);
        `CHK(v, 8'h84)
        wr(8'h23, 8'h00);
        wr(8'h23, 8'h14);
        span(1, 1'b1, n);
        span(1, 1'b0, n);
        `CHK(n >= 1 && n <= STEP, 1'b1)
        repeat (30) @(posedge mclk);
        rd(8'h23);
        `CHK(v, 8'h14)
        wr(8'h22, 8'h00);
        wr(8'h30, 8'h01);
        wr(8'h40, 8'h01);
        span(2, 1'b1, n);
        rd(8'h22);
        `CHK(v, 8'h84)
        dc_pulse;
        rd(8'h22);
        `CHK(v, 8'ha4)
        wr(8'h40, 8'h00);
        repeat (3) @(posedge mclk);
        #1 `CHK({ring_output_active, ring_drive_en}, 2'b01)
        dc_pulse;
        rd(8'h22);
        `CHK(v, 8'h00)
        wr(8'h24, 8'h5a);
        wr(8'h40, 8'h01);
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge mclk);
        #1 `CHK({act, ring_drive_en}, 4'h0)
        @(posedge mclk);
        sys_rst <= 1'b0;
        rd(8'h24);
        `CHK(v, 8'h00)
        give_verdict;
    end
endmodule
